// ==== logic/alarm_pkg.sv ====
// Constants and carrier types for the two alarm compare units
// How it works
// - Hundredths matching exists only in alarm 1
// - Hundredths register holds two BCD digits
// - Seconds: tens in 6:4, bit 7 zero
// - Minutes: tens in 6:4, bit 7 zero
// - Hours bit 6 mirrors time format, read-only
// - 12-hour: bit 5 afternoon, bit 4 tens
// - 24-hour: bits 5:4 hold hour tens
// - Flag cleared by writing zero, ones ignored
// - Date: tens in 5:4, bits 7:6 zero
// - Alarm 0 mask codes, 111 adds month
// - Alarm 1 mask codes, 101 hundredths
// - Selected comparison equal sets the flag
package alarm_pkg;
  localparam logic [7:0] OFS_A0_SEC = 8'h0C;
  localparam logic [7:0] OFS_A0_MIN = 8'h0D;
  localparam logic [7:0] OFS_A0_HOUR = 8'h0E;
  localparam logic [7:0] OFS_A0_WEEKDAY = 8'h0F;
  localparam logic [7:0] OFS_A0_DATE = 8'h10;
  localparam logic [7:0] OFS_A1_HSEC = 8'h12;
  localparam logic [7:0] OFS_A1_SEC = 8'h13;
  localparam logic [7:0] OFS_A1_MIN = 8'h14;
  localparam logic [7:0] OFS_A1_HOUR = 8'h15;
  localparam logic [7:0] OFS_A1_WEEKDAY = 8'h16;
  localparam logic [7:0] OFS_A1_DATE = 8'h17;
  localparam logic [7:0] SEC_MASK = 8'h7F;
  localparam logic [7:0] MIN_MASK = 8'h7F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] DATE_MASK = 8'h3F;
  localparam int FMT_BIT = 6;
  localparam int MSK_LSB = 4;
  localparam int FLAG_BIT = 3;
  localparam logic [2:0] WEEKDAY_RESET = 3'h1;
  localparam logic [5:0] DATE_RESET = 6'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    CMP_SEC = 3'b000,
    CMP_MIN = 3'b001,
    CMP_HOUR = 3'b010,
    CMP_WEEKDAY = 3'b011,
    CMP_DATE = 3'b100,
    CMP_HSEC = 3'b101,
    CMP_RSVD = 3'b110,
    CMP_ALL = 3'b111
  } cmp_sel_t;

  typedef struct packed {
    logic [7:0] hsec;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] date;
    logic [7:0] month;
  } time_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ==== logic/alarm_match.sv ====
// Two alarm compare units with their match registers
`timescale 1ns/100ps
module alarm_match #(
  parameter int NUM_ALARMS = 2
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic tick_in,
  input wire alarm_pkg::time_t time_in,
  input wire logic [7:0] month_match_in,
  input wire alarm_pkg::reg_req_t req_in,
  output logic [7:0] rdata_out,
  output logic [1:0] alarm_match_flag_out
);
  import alarm_pkg::*;

  if (NUM_ALARMS != 2)
  begin
    $error("alarm_match serves exactly two alarms");
  end

  logic rst_meta_r;
  logic rst_n;
  logic [6:0] sec_r [2];
  logic [6:0] min_r [2];
  logic [5:0] hour_r [2];
  logic [2:0] msk_r [2];
  logic [2:0] wkd_r [2];
  logic [5:0] date_r [2];
  logic [1:0] flag_r;
  logic [7:0] hsec_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] hit;
  logic [1:0] clr_wr;
  logic [1:0] flag_nxt;
  logic fmt;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  assign fmt = time_in.hour[FMT_BIT];

  // Hour byte as seen by readback and compare
  function automatic logic [7:0] hour_view(input logic f, input logic [5:0] h);
    hour_view = {1'b0, f, h};
  endfunction

  function automatic logic alarm_hit(input logic a1, input logic [2:0] m, input logic [6:0] s,
                                     input logic [6:0] mi, input logic [5:0] h, input logic [2:0] w,
                                     input logic [5:0] d, input logic [7:0] hs, input time_t t,
                                     input logic [7:0] mo);
    logic es;
    logic em;
    logic eh;
    logic ew;
    logic ed;
    // Status bits sharing the time bytes stay out of the compare
    es = (s == t.sec[6:0]);
    em = (mi == t.min[6:0]);
    eh = (hour_view(t.hour[FMT_BIT], h) == {1'b0, t.hour[6:0]});
    ew = (w == t.weekday[2:0]);
    ed = (d == t.date[5:0]);
    case (cmp_sel_t'(m))
      CMP_SEC: alarm_hit = es;
      CMP_MIN: alarm_hit = em;
      CMP_HOUR: alarm_hit = eh;
      CMP_WEEKDAY: alarm_hit = ew;
      CMP_DATE: alarm_hit = ed;
      CMP_HSEC: alarm_hit = a1 && (hs == t.hsec);
      CMP_ALL: alarm_hit = es && em && eh && ew && ed && (a1 || (mo[4:0] == t.month[4:0]));
      default: alarm_hit = 1'b0;
    endcase
  endfunction

  assign hit[0] = tick_in && alarm_hit(1'b0, msk_r[0], sec_r[0], min_r[0], hour_r[0], wkd_r[0],
                                       date_r[0], hsec_r, time_in, month_match_in);
  assign hit[1] = tick_in && alarm_hit(1'b1, msk_r[1], sec_r[1], min_r[1], hour_r[1], wkd_r[1],
                                       date_r[1], hsec_r, time_in, month_match_in);
  assign clr_wr[0] = req_in.wr && (req_in.addr == OFS_A0_WEEKDAY) && !req_in.wdata[FLAG_BIT];
  assign clr_wr[1] = req_in.wr && (req_in.addr == OFS_A1_WEEKDAY) && !req_in.wdata[FLAG_BIT];
  assign flag_nxt = hit | (flag_r & ~clr_wr);

  // Readback mux
  always_comb
  begin
    case (req_in.addr)
      OFS_A0_SEC: rdata_nxt = {1'b0, sec_r[0]};
      OFS_A0_MIN: rdata_nxt = {1'b0, min_r[0]};
      OFS_A0_HOUR: rdata_nxt = hour_view(fmt, hour_r[0]);
      OFS_A0_WEEKDAY: rdata_nxt = {1'b0, msk_r[0], flag_r[0], wkd_r[0]};
      OFS_A0_DATE: rdata_nxt = {2'h0, date_r[0]};
      OFS_A1_HSEC: rdata_nxt = hsec_r;
      OFS_A1_SEC: rdata_nxt = {1'b0, sec_r[1]};
      OFS_A1_MIN: rdata_nxt = {1'b0, min_r[1]};
      OFS_A1_HOUR: rdata_nxt = hour_view(fmt, hour_r[1]);
      OFS_A1_WEEKDAY: rdata_nxt = {1'b0, msk_r[1], flag_r[1], wkd_r[1]};
      OFS_A1_DATE: rdata_nxt = {2'h0, date_r[1]};
      default: rdata_nxt = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= ZERO_BYTE;
      flag_r <= 2'b00;
    end
    else
    begin
      flag_r <= flag_nxt;
      if (req_in.rd)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Match value storage, one write port
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hsec_r <= ZERO_BYTE;
      for (int i = 0; i < 2; i++)
      begin
        sec_r[i] <= 7'h00;
        min_r[i] <= 7'h00;
        hour_r[i] <= 6'h00;
        msk_r[i] <= 3'h0;
        wkd_r[i] <= WEEKDAY_RESET;
        date_r[i] <= DATE_RESET;
      end
    end
    else if (req_in.wr)
    begin
      case (req_in.addr)
        OFS_A0_SEC: sec_r[0] <= req_in.wdata[6:0];
        OFS_A0_MIN: min_r[0] <= req_in.wdata[6:0];
        OFS_A0_HOUR: hour_r[0] <= req_in.wdata[5:0];
        OFS_A0_WEEKDAY:
        begin
          msk_r[0] <= req_in.wdata[6:4];
          wkd_r[0] <= req_in.wdata[2:0];
        end
        OFS_A0_DATE: date_r[0] <= req_in.wdata[5:0];
        OFS_A1_HSEC: hsec_r <= req_in.wdata;
        OFS_A1_SEC: sec_r[1] <= req_in.wdata[6:0];
        OFS_A1_MIN: min_r[1] <= req_in.wdata[6:0];
        OFS_A1_HOUR: hour_r[1] <= req_in.wdata[5:0];
        OFS_A1_WEEKDAY:
        begin
          msk_r[1] <= req_in.wdata[6:4];
          wkd_r[1] <= req_in.wdata[2:0];
        end
        OFS_A1_DATE: date_r[1] <= req_in.wdata[5:0];
        default: hsec_r <= hsec_r;
      endcase
    end
  end

  assign rdata_out = rdata_r;
  assign alarm_match_flag_out = flag_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  property p_one_write_no_set;
    (req_in.wr && req_in.addr == OFS_A0_WEEKDAY && req_in.wdata[FLAG_BIT] && !flag_r[0] && !hit[0])
      |=> !alarm_match_flag_out[0];
  endproperty
  a_one_write_no_set: assert property (p_one_write_no_set) else $error("flag set by software");

  property p_zero_write_clears;
    (clr_wr[1] && !hit[1]) |=> !alarm_match_flag_out[1];
  endproperty
  a_zero_write_clears: assert property (p_zero_write_clears) else $error("flag not cleared");

  property p_hit_sets;
    hit[0] |=> alarm_match_flag_out[0];
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("match did not set flag");

  property p_no_spurious_set;
    (!alarm_match_flag_out[1] ##1 alarm_match_flag_out[1]) |-> $past(hit[1]);
  endproperty
  a_no_spurious_set: assert property (p_no_spurious_set) else $error("flag set without match");

  property p_a0_no_hsec;
    (msk_r[0] == CMP_HSEC || msk_r[0] == CMP_RSVD) |-> !hit[0];
  endproperty
  a_a0_no_hsec: assert property (p_a0_no_hsec) else $error("alarm 0 reserved code matched");

  property p_hour_mirror;
    (req_in.rd && req_in.addr == OFS_A1_HOUR) |=> (rdata_out[6] == $past(fmt) && !rdata_out[7]);
  endproperty
  a_hour_mirror: assert property (p_hour_mirror) else $error("hour format bit wrong");

  property p_sec_top_zero;
    (req_in.rd && (req_in.addr == OFS_A0_SEC || req_in.addr == OFS_A1_MIN)) |=> !rdata_out[7];
  endproperty
  a_sec_top_zero: assert property (p_sec_top_zero) else $error("seconds or minutes bit 7 set");

  property p_date_top_zero;
    (req_in.rd && req_in.addr == OFS_A0_DATE) |=> (rdata_out[7:6] == 2'b00);
  endproperty
  a_date_top_zero: assert property (p_date_top_zero) else $error("date bits 7:6 set");

  property p_hsec_readback;
    (req_in.wr && req_in.addr == OFS_A1_HSEC ##1 req_in.rd && req_in.addr == OFS_A1_HSEC && !req_in.wr)
      |=> rdata_out == $past(req_in.wdata, 2);
  endproperty
  a_hsec_readback: assert property (p_hsec_readback) else $error("hundredths readback wrong");

  property p_hit_sets_a1;
    hit[1] |=> alarm_match_flag_out[1];
  endproperty
  a_hit_sets_a1: assert property (p_hit_sets_a1) else $error("alarm 1 match did not set flag");

  property p_no_spurious_set_a0;
    (!alarm_match_flag_out[0] ##1 alarm_match_flag_out[0]) |-> $past(hit[0]);
  endproperty
  a_no_spurious_set_a0: assert property (p_no_spurious_set_a0) else $error("alarm 0 flag set without match");

  property p_one_write_no_set_a1;
    (req_in.wr && req_in.addr == OFS_A1_WEEKDAY && req_in.wdata[FLAG_BIT] && !flag_r[1] && !hit[1])
      |=> !alarm_match_flag_out[1];
  endproperty
  a_one_write_no_set_a1: assert property (p_one_write_no_set_a1) else $error("alarm 1 flag set by write");

  property p_zero_write_clears_a0;
    (clr_wr[0] && !hit[0]) |=> !alarm_match_flag_out[0];
  endproperty
  a_zero_write_clears_a0: assert property (p_zero_write_clears_a0) else $error("alarm 0 flag not cleared");

  property p_set_wins;
    (hit[0] && clr_wr[0]) |=> alarm_match_flag_out[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a match");

  property p_flag_holds;
    (flag_r[1] && !clr_wr[1]) |=> alarm_match_flag_out[1];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("alarm 1 flag dropped");

  property p_no_tick_no_hit;
    !tick_in |-> (hit == 2'b00);
  endproperty
  a_no_tick_no_hit: assert property (p_no_tick_no_hit) else $error("match outside tick");

  property p_a1_rsvd;
    (msk_r[1] == CMP_RSVD) |-> !hit[1];
  endproperty
  a_a1_rsvd: assert property (p_a1_rsvd) else $error("alarm 1 reserved code matched");

  property p_hsec_hit_a1;
    (tick_in && msk_r[1] == CMP_HSEC && hsec_r == time_in.hsec) |-> hit[1];
  endproperty
  a_hsec_hit_a1: assert property (p_hsec_hit_a1) else $error("hundredths match missed");

  property p_month_gate_a0;
    (msk_r[0] == CMP_ALL && month_match_in[4:0] != time_in.month[4:0]) |-> !hit[0];
  endproperty
  a_month_gate_a0: assert property (p_month_gate_a0) else $error("alarm 0 matched wrong month");

  property p_hour_cmp_a0;
    (msk_r[0] == CMP_HOUR && hour_r[0] != time_in.hour[5:0]) |-> !hit[0];
  endproperty
  a_hour_cmp_a0: assert property (p_hour_cmp_a0) else $error("alarm 0 matched wrong hour");

  property p_hour0_mirror;
    (req_in.rd && req_in.addr == OFS_A0_HOUR) |=> (rdata_out[6] == $past(fmt) && !rdata_out[7]);
  endproperty
  a_hour0_mirror: assert property (p_hour0_mirror) else $error("alarm 0 hour format bit wrong");

  property p_min_top_zero;
    (req_in.rd && (req_in.addr == OFS_A0_MIN || req_in.addr == OFS_A1_SEC)) |=> !rdata_out[7];
  endproperty
  a_min_top_zero: assert property (p_min_top_zero) else $error("minutes or seconds bit 7 set");

  property p_date1_top_zero;
    (req_in.rd && req_in.addr == OFS_A1_DATE) |=> (rdata_out[7:6] == 2'b00);
  endproperty
  a_date1_top_zero: assert property (p_date1_top_zero) else $error("alarm 1 date bits 7:6 set");

  property p_weekday_flag_view;
    (req_in.rd && req_in.addr == OFS_A0_WEEKDAY) |=> (rdata_out[FLAG_BIT] == $past(flag_r[0]) && !rdata_out[7]);
  endproperty
  a_weekday_flag_view: assert property (p_weekday_flag_view) else $error("weekday readback wrong");

  property p_hsec_store;
    (req_in.wr && req_in.addr == OFS_A1_HSEC) |=> (hsec_r == $past(req_in.wdata));
  endproperty
  a_hsec_store: assert property (p_hsec_store) else $error("hundredths not stored");
endmodule

// ==== test/alarm_match_test.sv ====
// Self-checking bench for the alarm compare units
`timescale 1ns/100ps
module alarm_match_test;
  import alarm_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic tick_in = 1'b0;
  time_t tv = '0;
  logic [7:0] month_val = 8'h05;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic [1:0] flags;
  int mismatches = 0;
  int comparisons = 0;
  always #5 clk_in = ~clk_in;
  alarm_match i_alarm_match (.clk_in(clk_in), .rstn_in(rstn_in), .tick_in(tick_in), .time_in(tv),
    .month_match_in(month_val), .req_in(req), .rdata_out(rdata), .alarm_match_flag_out(flags));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    #1 req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1 req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    #1 req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1 tick_in = 1'b1;
    @(posedge clk_in);
    #1 tick_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] d;
    rd(OFS_A0_WEEKDAY, d);
    chk(d, 8'h01);
    rd(OFS_A1_DATE, d);
    chk(d, 8'h01);
    rd(OFS_A1_SEC, d);
    chk(d, 8'h00);
    chk({6'h00, flags}, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_fields();
    logic [7:0] d;
    logic [7:0] fa [6];
    logic [7:0] fe [6];
    fa = '{OFS_A0_SEC, OFS_A0_MIN, OFS_A1_HOUR, OFS_A1_HSEC, OFS_A0_DATE, 8'h11};
    fe = '{8'h7F, 8'h7F, 8'h3F, 8'hFF, 8'h3F, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      wr(fa[i], 8'hFF);
      rd(fa[i], d);
      chk(d, fe[i]);
    end
    $display("field test done");
  endtask
  task automatic t_masks(input int a);
    logic [7:0] wk;
    logic ex;
    wr(a ? OFS_A1_SEC : OFS_A0_SEC, 8'h30);
    wr(a ? OFS_A1_MIN : OFS_A0_MIN, 8'h15);
    wr(a ? OFS_A1_HOUR : OFS_A0_HOUR, 8'h08);
    wr(a ? OFS_A1_DATE : OFS_A0_DATE, 8'h21);
    wr(OFS_A1_HSEC, 8'h42);
    wk = a ? OFS_A1_WEEKDAY : OFS_A0_WEEKDAY;
    tv = '{hsec: 8'h42, sec: 8'h30, min: 8'h15, hour: 8'h08, weekday: 8'h03, date: 8'h21, month: 8'h05};
    for (int c = 0; c < 8; c++)
    begin
      wr(wk, {1'b0, 3'(c), 4'h3});
      tick();
      ex = (c < 5) || (c == 7) || (a == 1 && c == 5);
      chk({7'h00, flags[a]}, {7'h00, ex});
    end
    month_val = 8'h06;
    wr(wk, 8'h73);
    tick();
    chk({7'h00, flags[a]}, {7'h00, a == 1});
    month_val = 8'h05;
    $display("mask test done");
  endtask
  task automatic t_flag();
    logic [7:0] d;
    wr(OFS_A0_WEEKDAY, 8'h03);
    tick();
    wr(OFS_A0_WEEKDAY, 8'h0B);
    chk({7'h00, flags[0]}, 8'h01);
    rd(OFS_A0_WEEKDAY, d);
    chk(d, 8'h0B);
    wr(OFS_A0_WEEKDAY, 8'h03);
    chk({7'h00, flags[0]}, 8'h00);
    wr(OFS_A0_WEEKDAY, 8'h0B);
    rd(OFS_A0_WEEKDAY, d);
    chk(d, 8'h03);
    $display("flag test done");
  endtask
  task automatic t_hours();
    logic [7:0] d;
    tv.hour = 8'h48;
    wr(OFS_A0_HOUR, 8'h08);
    rd(OFS_A0_HOUR, d);
    chk(d, 8'h48);
    wr(OFS_A0_WEEKDAY, 8'h23);
    tick();
    chk({7'h00, flags[0]}, 8'h01);
    wr(OFS_A0_WEEKDAY, 8'h23);
    tv.hour = 8'h68;
    tick();
    chk({7'h00, flags[0]}, 8'h00);
    $display("hours test done");
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    #1 req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    #1 req = '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    #1 req.rd = 1'b0;
    q = rdata;
  endtask
  task automatic t_status_bits();
    tv.sec = 8'hB0;
    tv.hour = 8'h08;
    tv.weekday = 8'h2B;
    tv.month = 8'h25;
    wr(OFS_A0_WEEKDAY, 8'h03);
    tick();
    chk({7'h00, flags[0]}, 8'h01);
    wr(OFS_A0_WEEKDAY, 8'h33);
    tick();
    chk({7'h00, flags[0]}, 8'h01);
    wr(OFS_A0_WEEKDAY, 8'h73);
    tick();
    chk({7'h00, flags[0]}, 8'h01);
    $display("status bits test done");
  endtask
  task automatic t_set_wins();
    wr(OFS_A0_WEEKDAY, 8'h03);
    @(posedge clk_in);
    #1 req = '{addr: OFS_A0_WEEKDAY, wdata: 8'h03, wr: 1'b1, rd: 1'b0};
    tick_in = 1'b1;
    @(posedge clk_in);
    #1 req.wr = 1'b0;
    tick_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk({7'h00, flags[0]}, 8'h01);
    wr(OFS_A0_WEEKDAY, 8'h03);
    chk({7'h00, flags[0]}, 8'h00);
    wr(OFS_A1_WEEKDAY, 8'h03);
    wr(OFS_A1_WEEKDAY, 8'h0B);
    chk({7'h00, flags[1]}, 8'h00);
    $display("set wins test done");
  endtask
  task automatic t_backtoback();
    logic [7:0] d;
    wr_rd(OFS_A1_HSEC, 8'h97, d);
    chk(d, 8'h97);
    wr_rd(OFS_A0_DATE, 8'h31, d);
    chk(d, 8'h31);
    $display("back to back test done");
  endtask
  task automatic t_mid_reset();
    logic [7:0] d;
    wr(OFS_A0_WEEKDAY, 8'h03);
    tick();
    chk({7'h00, flags[0]}, 8'h01);
    @(posedge clk_in);
    #1 rstn_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk({6'h00, flags}, 8'h00);
    rstn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    rd(OFS_A0_WEEKDAY, d);
    chk(d, 8'h01);
    rd(OFS_A0_SEC, d);
    chk(d, 8'h00);
    $display("mid-run reset test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_fields();
    t_masks(0);
    t_masks(1);
    t_flag();
    t_hours();
    t_status_bits();
    t_set_wins();
    t_backtoback();
    t_mid_reset();
    close_out();
  end
endmodule
